// ---- hdl/spcm_shifter.sv ----
// Byte shifter for master and slave roles.
`timescale 1ns/1ps
`default_nettype none
module spcm_shifter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic sclk_s,
  input wire logic cs_n_s,
  input wire logic din_s,
  output logic sclk_o,
  output logic dout,
  spcm_link_if.shift lk
);
  spcm_pkg::spcm_phase_e ph_reg, ph_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] rx_reg, rx_next;
  logic [3:0] cnt_reg, cnt_next;
  logic sclk_reg, sclk_next;
  logic prev_reg, prev_next;
  logic done_reg, done_next;
  logic lsb_reg, lsb_next;
  logic pol_reg, pol_next;
  logic pha_reg, pha_next;
  logic mst_reg, mst_next;
  logic lead, trail, lvl;
  logic out_bit;

  assign lvl = sclk_s ^ pol_reg;
  assign out_bit = lsb_reg ? sh_reg[0] : sh_reg[7];
  // In master mode the phase counter walks on tick; as slave, pin edges.
  assign lead = mst_reg ? (tick && ph_reg == spcm_pkg::SPCM_FIRST)
                        : (lvl && !prev_reg && !cs_n_s);
  assign trail = mst_reg ? (tick && ph_reg == spcm_pkg::SPCM_SECOND)
                         : (!lvl && prev_reg && !cs_n_s);

  always_comb begin
    ph_next = ph_reg;
    sh_next = sh_reg;
    rx_next = rx_reg;
    cnt_next = cnt_reg;
    sclk_next = sclk_reg;
    prev_next = lvl;
    done_next = 1'b0;
    lsb_next = lsb_reg;
    pol_next = pol_reg;
    pha_next = pha_reg;
    mst_next = mst_reg;
    if (ph_reg == spcm_pkg::SPCM_IDLE) begin
      lsb_next = lk.lsb_first;
      pol_next = lk.cpol;
      pha_next = lk.cpha;
      mst_next = lk.master;
      sclk_next = lk.cpol;
      prev_next = 1'b0;
      if (lk.start) begin
        ph_next = spcm_pkg::SPCM_FIRST;
        sh_next = lk.tx_byte;
        cnt_next = 4'h0;
      end
    end else begin
      // A master ends one half bit after the last bit, so that the final
      // clock pulse of a phase-clear frame is completed before idling.
      if (lead) begin
        if (mst_reg && cnt_reg == spcm_pkg::BIT_COUNT) begin
          ph_next = spcm_pkg::SPCM_IDLE;
          done_next = 1'b1;
          sclk_next = pol_reg;
        end else begin
          if (mst_reg) begin
            ph_next = spcm_pkg::SPCM_SECOND;
            sclk_next = pha_reg ? ~pol_reg : pol_reg;
            // Data moves at bit boundaries, away from the sampling edge.
            if (cnt_reg != 4'h0) begin
              sh_next = lsb_reg ? {1'b0, sh_reg[7:1]} : {sh_reg[6:0], 1'b0};
            end
          end
          if (!pha_reg && !mst_reg) begin
            rx_next = lsb_reg ? {din_s, rx_reg[7:1]} : {rx_reg[6:0], din_s};
          end
        end
      end
      if (trail) begin
        if (mst_reg) begin
          sclk_next = pha_reg ? pol_reg : ~pol_reg;
        end
        if (pha_reg || mst_reg) begin
          rx_next = lsb_reg ? {din_s, rx_reg[7:1]} : {rx_reg[6:0], din_s};
        end
        if (!mst_reg) begin
          sh_next = lsb_reg ? {1'b0, sh_reg[7:1]} : {sh_reg[6:0], 1'b0};
        end
        cnt_next = cnt_reg + 4'h1;
        if (mst_reg) begin
          ph_next = spcm_pkg::SPCM_FIRST;
        end else if (cnt_reg + 4'h1 == spcm_pkg::BIT_COUNT) begin
          ph_next = spcm_pkg::SPCM_IDLE;
          done_next = 1'b1;
        end
      end
      if (!mst_reg && cs_n_s) begin
        ph_next = spcm_pkg::SPCM_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_reg <= spcm_pkg::SPCM_IDLE;
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      cnt_reg <= 4'h0;
      sclk_reg <= 1'b0;
      prev_reg <= 1'b0;
      done_reg <= 1'b0;
      lsb_reg <= 1'b0;
      pol_reg <= 1'b0;
      pha_reg <= 1'b0;
      mst_reg <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      sh_reg <= sh_next;
      rx_reg <= rx_next;
      cnt_reg <= cnt_next;
      sclk_reg <= sclk_next;
      prev_reg <= prev_next;
      done_reg <= done_next;
      lsb_reg <= lsb_next;
      pol_reg <= pol_next;
      pha_reg <= pha_next;
      mst_reg <= mst_next;
    end
  end

  assign sclk_o = sclk_reg;
  assign dout = out_bit;
  assign lk.busy = (ph_reg != spcm_pkg::SPCM_IDLE);
  assign lk.done = done_reg;
  assign lk.rx_byte = rx_reg;
endmodule : spcm_shifter
`default_nettype wire

// ---- hdl/spcm_sync.sv ----
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module spcm_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);
  logic meta_reg;
  logic meta_next;
  logic out_next;
  always_comb begin
    meta_next = din;
    out_next = meta_reg;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      dout <= out_next;
    end
  end
endmodule : spcm_sync
`default_nettype wire

// ---- hdl/spcm_top.sv ----
// Serial peripheral port with control register, divider and interrupts.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module spcm_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  output logic irq,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic cs_n_i,
  output logic cs_n_o,
  output logic cs_n_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe
);
  spcm_link_if lk ();
  logic sclk_s, cs_n_s, mosi_s, miso_s;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [7:0] div_reg, div_next;
  logic [7:0] dcnt_reg, dcnt_next;
  logic tick;
  logic [7:0] txd_reg, txd_next;
  logic txv_reg, txv_next;
  logic [7:0] last_reg, last_next;
  logic [7:0] rxd_reg, rxd_next;
  logic rxv_reg, rxv_next;
  logic [2:0] ist_reg, ist_next;
  logic [2:0] imsk_reg, imsk_next;
  logic [15:0] rdata_next;
  logic start;
  logic [7:0] send_byte;
  logic en, mst, wom, sout, wr_tx, rd_rx;
  logic [2:0] ev;

  spcm_sync u_sync_sclk (.clk(clk), .sys_rst(sys_rst), .din(sclk_i),
    .dout(sclk_s));
  spcm_sync u_sync_cs (.clk(clk), .sys_rst(sys_rst), .din(cs_n_i),
    .dout(cs_n_s));
  spcm_sync u_sync_mosi (.clk(clk), .sys_rst(sys_rst), .din(mosi_i),
    .dout(mosi_s));
  spcm_sync u_sync_miso (.clk(clk), .sys_rst(sys_rst), .din(miso_i),
    .dout(miso_s));

  spcm_shifter u_shift (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .sclk_s(sclk_s),
    .cs_n_s(cs_n_s),
    .din_s(mst ? miso_s : mosi_s),
    .sclk_o(sclk_o),
    .dout(sout),
    .lk(lk.shift)
  );

  assign en = ctrl_reg[spcm_pkg::B_EN];
  assign mst = ctrl_reg[spcm_pkg::B_MASTER];
  assign wom = ctrl_reg[spcm_pkg::B_WOM];
  assign wr_tx = wr_en && addr == spcm_pkg::ADDR_TX;
  assign rd_rx = rd_en && addr == spcm_pkg::ADDR_RX;

  // Divider gives the half-bit enable for master clocking.
  assign tick = (dcnt_reg == 8'h00);

  // An empty or flushed queue shifts the fill byte.
  always_comb begin
    if (txv_reg && !ctrl_reg[spcm_pkg::B_TFLH]) begin
      send_byte = txd_reg;
    end else if (ctrl_reg[spcm_pkg::B_ZEN]) begin
      send_byte = spcm_pkg::ZERO_BYTE;
    end else begin
      send_byte = last_reg;
    end
  end

  // A master starts bytes on queued data or an RX read; a slave starts whenever enabled and selected.
  always_comb begin
    start = 1'b0;
    if (en && !lk.busy) begin
      if (!mst) begin
        start = !cs_n_s;
      end else if (ctrl_reg[spcm_pkg::B_TMDE]) begin
        start = txv_reg;
      end else begin
        start = rd_rx;
      end
    end
  end

  assign lk.start = start;
  assign lk.tx_byte = send_byte;
  assign lk.lsb_first = ctrl_reg[spcm_pkg::B_LSB];
  assign lk.cpol = ctrl_reg[spcm_pkg::B_CPOL];
  assign lk.cpha = ctrl_reg[spcm_pkg::B_CPHA];
  assign lk.master = mst;

  always_comb begin
    ctrl_next = ctrl_reg;
    div_next = div_reg;
    dcnt_next = (tick || !lk.busy) ? div_reg : dcnt_reg - 8'h01;
    txd_next = txd_reg;
    txv_next = txv_reg;
    last_next = last_reg;
    rxd_next = rxd_reg;
    rxv_next = rxv_reg;
    imsk_next = imsk_reg;
    ev = 3'h0;
    if (wr_en && addr == spcm_pkg::ADDR_CTRL) begin
      ctrl_next = wdata;
    end
    if (wr_en && addr == spcm_pkg::ADDR_DIV) begin
      div_next = wdata[7:0];
    end
    if (wr_en && addr == spcm_pkg::ADDR_IRQ_MASK) begin
      imsk_next = wdata[2:0];
    end
    if (wr_tx && !ctrl_reg[spcm_pkg::B_TFLH]) begin
      txd_next = wdata[7:0];
      txv_next = 1'b1;
    end
    if (rd_rx) begin
      rxv_next = 1'b0;
    end
    if (start) begin
      last_next = send_byte;
      if (txv_reg && !ctrl_reg[spcm_pkg::B_TFLH]) begin
        txv_next = 1'b0;
        ev[spcm_pkg::IRQ_TX] = ctrl_reg[spcm_pkg::B_TMDE] && !wr_tx;
      end
    end
    if (lk.done && en && !ctrl_reg[spcm_pkg::B_RFLH]) begin
      if (!rxv_reg || rd_rx || ctrl_reg[spcm_pkg::B_ROW]) begin
        rxd_next = lk.rx_byte;
        rxv_next = 1'b1;
        ev[spcm_pkg::IRQ_RX] = !ctrl_reg[spcm_pkg::B_TMDE];
      end
      ev[spcm_pkg::IRQ_OVF] = rxv_reg && !rd_rx;
    end
    // A new event wins over a write-one clear in the same cycle.
    ist_next = ist_reg;
    if (wr_en && addr == spcm_pkg::ADDR_IRQ_STAT) begin
      ist_next = ist_reg & ~wdata[2:0];
    end
    ist_next = ist_next | ev;
  end

  always_comb begin
    rdata_next = 16'h0000;
    if (rd_en) begin
      unique case (addr)
        spcm_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
        spcm_pkg::ADDR_RX: rdata_next = {8'h00, rxd_reg};
        spcm_pkg::ADDR_DIV: rdata_next = {8'h00, div_reg};
        spcm_pkg::ADDR_IRQ_STAT: rdata_next = {13'h0000, ist_reg};
        spcm_pkg::ADDR_IRQ_MASK: rdata_next = {13'h0000, imsk_reg};
        spcm_pkg::ADDR_STATUS: rdata_next = {13'h0000, lk.busy, rxv_reg,
          txv_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= spcm_pkg::CTRL_RESET;
      div_reg <= spcm_pkg::DIV_RESET;
      dcnt_reg <= spcm_pkg::DIV_RESET;
      txd_reg <= 8'h00;
      txv_reg <= 1'b0;
      last_reg <= 8'h00;
      rxd_reg <= 8'h00;
      rxv_reg <= 1'b0;
      ist_reg <= spcm_pkg::IRQ_RESET;
      imsk_reg <= spcm_pkg::IRQ_RESET;
      rdata <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      div_reg <= div_next;
      dcnt_reg <= dcnt_next;
      txd_reg <= txd_next;
      txv_reg <= txv_next;
      last_reg <= last_next;
      rxd_reg <= rxd_next;
      rxv_reg <= rxv_next;
      ist_reg <= ist_next;
      imsk_reg <= imsk_next;
      rdata <= rdata_next;
    end
  end

  assign irq = |(ist_reg & imsk_reg);
  // Pins idle undriven when disabled; open-drain only pulls low.
  assign sclk_oe = en && mst;
  assign cs_n_o = !lk.busy;
  assign cs_n_oe = en && mst;
  assign mosi_o = sout;
  assign mosi_oe = en && mst && lk.busy && (!wom || !sout);
  assign miso_o = sout;
  assign miso_oe = en && !mst && !cs_n_s && (!wom || !sout);
endmodule : spcm_top
`default_nettype wire

// ---- inc/spcm_link_if.sv ----
// Interface carrying shifter control and results between modules.
`timescale 1ns/1ps
`default_nettype none
interface spcm_link_if;
  logic start;
  logic [7:0] tx_byte;
  logic lsb_first;
  logic cpol;
  logic cpha;
  logic master;
  logic busy;
  logic done;
  logic [7:0] rx_byte;
  modport ctrl(output start, tx_byte, lsb_first, cpol, cpha, master,
               input busy, done, rx_byte);
  modport shift(input start, tx_byte, lsb_first, cpol, cpha, master,
                output busy, done, rx_byte);
endinterface : spcm_link_if
`default_nettype wire

// ---- inc/spcm_pkg.sv ----
// Package of constants for the serial port control block.
// Notes on behaviour
// - Overwrite bit set replaces unread receive byte
// - Empty transmit sends zero or last byte
// - Trigger bit set: write starts, tx-empty interrupt
// - Trigger bit clear: read starts, rx-full interrupt
// - Order bit set shifts least significant first
// - Wired-or bit makes data outputs open-drain
// - Polarity bit sets serial clock idle level
// - Phase bit puts clock pulse at bit start
// - Role bit chooses master or slave
// - Enable bit clear switches port off
// - Transmit flush ignores writes, sends fill byte
// - Receive flush discards data, read still starts
package spcm_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TX = 4'h1;
  localparam logic [3:0] ADDR_RX = 4'h2;
  localparam logic [3:0] ADDR_DIV = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam int B_EN = 0;
  localparam int B_MASTER = 1;
  localparam int B_CPHA = 2;
  localparam int B_CPOL = 3;
  localparam int B_WOM = 4;
  localparam int B_LSB = 5;
  localparam int B_TMDE = 6;
  localparam int B_ZEN = 7;
  localparam int B_ROW = 8;
  localparam int B_RFLH = 12;
  localparam int B_TFLH = 13;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] DIV_RESET = 8'h1B;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_OVF = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  typedef enum logic [1:0] {SPCM_IDLE, SPCM_FIRST, SPCM_SECOND} spcm_phase_e;
endpackage : spcm_pkg

// ---- sim/spcm_chk.sv ----
// Assertion checker for the serial port control block.
`timescale 1ns/1ps
`default_nettype none
module spcm_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic cs_n_o,
  input wire logic cs_n_oe,
  input wire logic mosi_o,
  input wire logic mosi_oe,
  input wire logic miso_oe
);
  logic [15:0] ctl;
  logic [1:0] quiet;
  logic [4:0] tog;
  logic sclk_q;
  logic st;
  // Mode bits are judged only once a control write has had time to land.
  assign st = (quiet == 2'h3);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl <= 16'h0000;
      quiet <= 2'h3;
      tog <= 5'h00;
      sclk_q <= 1'h0;
    end else begin
      sclk_q <= sclk_o;
      if (wr_en && addr == spcm_pkg::ADDR_CTRL) begin
        ctl <= wdata;
        quiet <= 2'h0;
      end else if (!st) begin
        quiet <= quiet + 2'h1;
      end
      if (cs_n_o) begin
        tog <= 5'h00;
      end else if (sclk_o != sclk_q) begin
        tog <= tog + 5'h01;
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_idle_pol;
    st && ctl[0] && ctl[1] && cs_n_o |-> sclk_o == ctl[3];
  endproperty
  a_idle_pol: assert property (p_idle_pol)
    else $error("serial clock idle level wrong");
  property p_off;
    st && !ctl[0] |-> cs_n_o && !sclk_oe && !cs_n_oe && !mosi_oe && !miso_oe;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled port drives pins");
  property p_master;
    st && ctl[0] && ctl[1] |-> sclk_oe && cs_n_oe;
  endproperty
  a_master: assert property (p_master)
    else $error("master does not drive clock");
  property p_slave;
    st && !ctl[1] |-> !sclk_oe && !cs_n_oe;
  endproperty
  a_slave: assert property (p_slave)
    else $error("slave drives clock");
  property p_data_drive;
    st && ctl[0] && ctl[1] && !cs_n_o |-> mosi_oe == (!ctl[4] || !mosi_o);
  endproperty
  a_data_drive: assert property (p_data_drive)
    else $error("data drive mode wrong");
  property p_frame;
    $rose(cs_n_o) && sclk_oe |->
      tog == 5'h10 || (tog == 5'h0F && sclk_o != sclk_q);
  endproperty
  a_frame: assert property (p_frame)
    else $error("clock pulse count wrong");
  property p_wr_start;
    st && ctl[0] && ctl[1] && ctl[6] && !ctl[13] && wr_en &&
      addr == spcm_pkg::ADDR_TX && cs_n_o |-> ##[1:4] !cs_n_o;
  endproperty
  a_wr_start: assert property (p_wr_start)
    else $error("write did not start transfer");
  property p_rd_start;
    st && ctl[0] && ctl[1] && !ctl[6] && rd_en &&
      addr == spcm_pkg::ADDR_RX && cs_n_o |-> ##[1:4] !cs_n_o;
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("read did not start transfer");
  property p_flush_wr;
    st && ctl[6] && ctl[13] && wr_en && addr == spcm_pkg::ADDR_TX && cs_n_o
      |-> cs_n_o [*6];
  endproperty
  a_flush_wr: assert property (p_flush_wr)
    else $error("flushed write started transfer");
endmodule : spcm_chk
bind spcm_top spcm_chk spcm_chk_i (.clk, .sys_rst, .addr, .wdata, .wr_en,
  .rd_en, .sclk_o, .sclk_oe, .cs_n_o, .cs_n_oe, .mosi_o, .mosi_oe, .miso_oe);
`default_nettype wire

// ---- sim/spcm_peer.sv ----
// Behavioural far-side slave device for the serial port.
`timescale 1ns/1ps
`default_nettype none
module spcm_peer (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output logic [7:0] frames
);
  int n;
  // Past the last bit the line shows garbage, so stale data cannot pass.
  task automatic put;
    if (n < 8) miso = tx_byte[lsb ? n : 7 - n];
    else miso = ~miso;
    n++;
  endtask : put
  initial begin
    miso = 1'h0;
    rx_byte = 8'h00;
    frames = 8'h00;
    n = 0;
  end
  always @(negedge cs_n) begin
    n = 0;
    frames = frames + 8'h01;
    if (!cpha) put();
  end
  always @(posedge cs_n) miso = ~miso;
  always @(sclk) begin
    if (!cs_n) begin
      if ((sclk != cpol) ^ cpha) begin
        rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      end else begin
        put();
      end
    end
  end
endmodule : spcm_peer
`default_nettype wire

// ---- sim/test_spcm_top.sv ----
// Self-checking testbench for the serial port control block.
`timescale 1ns/1ps
`default_nettype none
`define chk_eq(g, e) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end end
module test_spcm_top;
  logic clk, sys_rst, wr_en, rd_en, irq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic sclk_o, sclk_oe, cs_n_o, cs_n_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic sclk_w, cs_w, mosi_w, miso_w, p_miso, p_cpol, p_cpha, p_lsb;
  logic [7:0] p_tx, p_rx, p_fr, fr0;
  int check_count, miscompares;
  assign sclk_w = sclk_oe ? sclk_o : 1'h1;
  assign cs_w = cs_n_oe ? cs_n_o : 1'h1;
  // The MOSI line carries a pull-up, which open-drain mode depends on; MISO falls back to the peer.
  assign mosi_w = mosi_oe ? mosi_o : 1'h1;
  assign miso_w = miso_oe ? miso_o : p_miso;
  spcm_top spcm_top_i (.clk, .sys_rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .irq, .sclk_i(sclk_w), .sclk_o, .sclk_oe, .cs_n_i(cs_w), .cs_n_o,
    .cs_n_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o,
    .miso_oe);
  spcm_peer spcm_peer_i (.sclk(sclk_w), .cs_n(cs_w), .mosi(mosi_w),
    .cpol(p_cpol), .cpha(p_cpha), .lsb(p_lsb), .tx_byte(p_tx), .miso(p_miso),
    .rx_byte(p_rx), .frames(p_fr));
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input bit c);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    if (c) `chk_eq(rdata, e)
    @(posedge clk);
  endtask : rd
  task automatic frame_wait;
    int i;
    i = 0;
    while (cs_w && i < 100) begin
      @(posedge clk);
      i++;
    end
    while (!cs_w && i < 400) begin
      @(posedge clk);
      i++;
    end
    repeat (3) @(posedge clk);
  endtask : frame_wait
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    {sys_rst, wr_en, rd_en, addr, wdata} = {1'h1, 22'h000000};
    {p_cpol, p_cpha, p_lsb, p_tx} = 11'h000;
    check_count = 0;
    miscompares = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(spcm_pkg::ADDR_CTRL, 16'h0000, 1'h1);
    rd(4'hF, 16'h0000, 1'h1);
    wr(spcm_pkg::ADDR_DIV, 16'h0003);
    wr(spcm_pkg::ADDR_IRQ_MASK, 16'h0007);
    for (int m = 0; m < 4; m++) begin
      p_cpha <= m[0];
      p_cpol <= m[1];
      p_lsb <= m[0] ^ m[1];
      p_tx <= 8'h3C + m[7:0];
      wr(spcm_pkg::ADDR_CTRL, {10'h000, m[0] ^ m[1], 1'h0, m[1:0], 2'h3} |
        16'h0040);
      wr(spcm_pkg::ADDR_TX, 16'h0096 ^ m[15:0]);
      frame_wait();
      `chk_eq(p_rx, 8'h96 ^ m[7:0])
      rd(spcm_pkg::ADDR_RX, {8'h00, 8'h3C + m[7:0]}, 1'h1);
      `chk_eq(irq, 1'h1)
      rd(spcm_pkg::ADDR_IRQ_STAT, 16'h0001, 1'h1);
      wr(spcm_pkg::ADDR_IRQ_STAT, 16'h0007);
    end
    {p_cpha, p_cpol, p_lsb} <= 3'h0;
    for (int r = 0; r < 2; r++) begin
      wr(spcm_pkg::ADDR_CTRL, {7'h00, r[0], 8'h43});
      p_tx <= 8'hA1;
      wr(spcm_pkg::ADDR_TX, 16'h0011);
      frame_wait();
      p_tx <= 8'hB2;
      wr(spcm_pkg::ADDR_TX, 16'h0022);
      frame_wait();
      rd(spcm_pkg::ADDR_RX, r ? 16'h00B2 : 16'h00A1, 1'h1);
      rd(spcm_pkg::ADDR_IRQ_STAT, 16'h0005, 1'h1);
      wr(spcm_pkg::ADDR_IRQ_STAT, 16'h0007);
    end
    wr(spcm_pkg::ADDR_CTRL, 16'h2043);
    wr(spcm_pkg::ADDR_TX, 16'h00AB);
    wr(spcm_pkg::ADDR_CTRL, 16'h2003);
    rd(spcm_pkg::ADDR_RX, 16'h0000, 1'h0);
    frame_wait();
    `chk_eq(p_rx, 8'h22)
    wr(spcm_pkg::ADDR_IRQ_STAT, 16'h0007);
    for (int z = 0; z < 2; z++) begin
      wr(spcm_pkg::ADDR_CTRL, {8'h00, z[0], 7'h03});
      rd(spcm_pkg::ADDR_RX, 16'h0000, 1'h0);
      frame_wait();
      `chk_eq(p_rx, z ? 8'h00 : 8'h22)
      rd(spcm_pkg::ADDR_IRQ_STAT, 16'h0002, 1'h1);
      wr(spcm_pkg::ADDR_IRQ_MASK, 16'h0000);
      `chk_eq(irq, 1'h0)
      wr(spcm_pkg::ADDR_IRQ_MASK, 16'h0007);
      `chk_eq(irq, 1'h1)
      wr(spcm_pkg::ADDR_IRQ_STAT, 16'h0007);
      `chk_eq(irq, 1'h0)
    end
    fr0 = p_fr;
    wr(spcm_pkg::ADDR_CTRL, 16'h1003);
    rd(spcm_pkg::ADDR_RX, 16'h0000, 1'h0);
    frame_wait();
    `chk_eq(p_fr, fr0 + 8'h01)
    rd(spcm_pkg::ADDR_IRQ_STAT, 16'h0000, 1'h1);
    wr(spcm_pkg::ADDR_CTRL, 16'h0053);
    wr(spcm_pkg::ADDR_TX, 16'h005A);
    frame_wait();
    `chk_eq(p_rx, 8'h5A)
    wr(spcm_pkg::ADDR_IRQ_STAT, 16'h0007);
    wr(spcm_pkg::ADDR_CTRL, 16'h0001);
    repeat (5) @(posedge clk);
    fr0 = p_fr;
    wr(spcm_pkg::ADDR_CTRL, 16'h0042);
    wr(spcm_pkg::ADDR_TX, 16'h0055);
    repeat (100) @(posedge clk);
    `chk_eq(p_fr, fr0)
    rd(spcm_pkg::ADDR_IRQ_STAT, 16'h0000, 1'h1);
    final_report();
  end
endmodule : test_spcm_top
`default_nettype wire
